/* File: rtl/pdc_pkg.sv */
// What this block does
// - Select clear: power-down instruction ignored while interrupt pin is high.
// - Select set: instruction ignored if any selected port 2 wake pin is active.
// - Otherwise power-down is entered normally.
// - Quasi-idle instead of ignoring when following code is external and multiplexed bus has no tri-state wait.
// - Quasi-idle also after external or extension peripheral write, following code external.
// - In quasi-idle peripherals run; enabled watchdog overflow resets the device.
// - In quasi-idle no interrupt service and no peripheral event transfers.
// - From quasi-idle, interrupt pin driven low enters power-down.
package pdc_pkg;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int unsigned PORT2_WIDTH = 16;
    localparam logic [PORT2_WIDTH-1:0] PORT2_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum {
        PDC_RUN,
        PDC_QUASI_IDLE,
        PDC_POWER_DOWN
    } pdc_state_type;

    // Context of the executed power-down instruction
    typedef struct packed {
        logic power_down_instruction;
        logic next_code_external;
        logic prev_write_external;
        logic bus_multiplexed;
        logic tristate_wait_control;
    } pdc_exec_type;

    typedef struct packed {
        logic fetch_enable;
        logic core_clock_enable;
        logic interrupt_enable;
        logic peripheral_event_transfer_enable;
        logic quasi_idle;
        logic power_down;
    } pdc_ctrl_type;

endpackage

/* File: rtl/pdc_wake_eval.sv */
`timescale 1ns/10ps
module pdc_wake_eval
    import pdc_pkg::*;
#(
    parameter int unsigned WIDTH = PORT2_WIDTH
)
(
    input  wire logic             wake_source_select,
    input  wire logic             nmi_n,
    input  wire logic [WIDTH-1:0] port2_pins,
    input  wire logic [WIDTH-1:0] port2_wake_enable,
    input  wire logic [WIDTH-1:0] port2_active_high,
    output logic                  wake_active
);
    logic [WIDTH-1:0] pin_active;

    always_comb
    begin
        pin_active = ~(port2_pins ^ port2_active_high) & port2_wake_enable;
        if (wake_source_select)
        begin
            wake_active = |pin_active;
        end
        else
        begin
            wake_active = nmi_n;
        end
    end
endmodule // pdc_wake_eval

/* File: rtl/pdc_power_down_entry_control.sv */
`timescale 1ns/10ps
module pdc_power_down_entry_control
    import pdc_pkg::*;
#(
    parameter int unsigned WIDTH = PORT2_WIDTH
)
(
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               wake_source_select,
    input  wire logic               nmi_n,
    input  wire logic [WIDTH-1:0]   port2_pins,
    input  wire logic [WIDTH-1:0]   port2_wake_enable,
    input  wire logic [WIDTH-1:0]   port2_active_high,
    input  pdc_pkg::pdc_exec_type   exec_info,
    input  wire logic               watchdog_enable,
    input  wire logic               watchdog_overflow,
    output pdc_pkg::pdc_ctrl_type   ctrl,
    output logic                    watchdog_reset_req
);
    import pdc_pkg::*;

    // ------------------------------------------------------------
    // Wake source evaluation
    // ------------------------------------------------------------
    logic wake_active;
    logic fault_cond;

    pdc_wake_eval #(.WIDTH(WIDTH)) u_wake (
        .wake_source_select (wake_source_select),
        .nmi_n              (nmi_n),
        .port2_pins         (port2_pins),
        .port2_wake_enable  (port2_wake_enable),
        .port2_active_high  (port2_active_high),
        .wake_active        (wake_active)
    );

    // No tri-state wait on a multiplexed bus, or a preceding external write
    assign fault_cond = exec_info.next_code_external &&
        ((exec_info.bus_multiplexed && !exec_info.tristate_wait_control) ||
         exec_info.prev_write_external);

    // ------------------------------------------------------------
    // Mode state
    // ------------------------------------------------------------
    pdc_state_type state_q;
    pdc_state_type state_d;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            PDC_RUN:
            begin
                // Fault only bites where the instruction would be ignored
                if (exec_info.power_down_instruction)
                begin
                    if (!wake_active)
                        state_d = PDC_POWER_DOWN;
                    else if (fault_cond)
                        state_d = PDC_QUASI_IDLE;
                    // Wake active, no fault: instruction ignored
                end
            end
            PDC_QUASI_IDLE:
            begin
                // Only a low interrupt pin helps, whatever the select bit
                if (!nmi_n)
                    state_d = PDC_POWER_DOWN;
            end
            PDC_POWER_DOWN:
            begin
                if (wake_active)
                    state_d = PDC_RUN;
            end
            default:
                state_d = PDC_RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            state_q <= PDC_RUN;
        else
            state_q <= state_d;
    end

    // ------------------------------------------------------------
    // Watchdog escape from quasi-idle
    // ------------------------------------------------------------
    logic wdt_req_q;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            wdt_req_q <= 1'b0;
        else
            wdt_req_q <= watchdog_enable && watchdog_overflow &&
                         state_q != PDC_POWER_DOWN;
    end

    assign watchdog_reset_req = wdt_req_q;

    // ------------------------------------------------------------
    // Control outputs, registered
    // ------------------------------------------------------------
    pdc_ctrl_type ctrl_q;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ctrl_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        end
        else
        begin
            ctrl_q.fetch_enable                     <= state_d == PDC_RUN;
            ctrl_q.core_clock_enable                <= state_d != PDC_POWER_DOWN;
            ctrl_q.interrupt_enable                 <= state_d == PDC_RUN;
            ctrl_q.peripheral_event_transfer_enable <= state_d == PDC_RUN;
            ctrl_q.quasi_idle                       <= state_d == PDC_QUASI_IDLE;
            ctrl_q.power_down                       <= state_d == PDC_POWER_DOWN;
        end
    end

    assign ctrl = ctrl_q;
endmodule // pdc_power_down_entry_control

/* File: verif/pdc_mem_model.sv */
`timescale 1ns/10ps
module pdc_mem_model
    import pdc_pkg::*;
(
    input  wire logic [1:0] kind,
    input  wire logic       pd,
    output pdc_pkg::pdc_exec_type ctx
);
    // Kind 0: internal code after a no-op; 1, 2 misplace the code on purpose
    // Kind 3: external code, multiplexed bus with tri-state wait
    assign ctx = {pd, kind != 2'h0, kind == 2'h2, kind[0], kind == 2'h3};
endmodule // pdc_mem_model

/* File: verif/pdc_props.sv */
`timescale 1ns/10ps
module pdc_props
    import pdc_pkg::*;
#(
    parameter int unsigned WIDTH = PORT2_WIDTH
)
(
    input  wire logic     clk,
    input  wire logic     nrst,
    input  wire logic     wake_source_select,
    input  wire logic     nmi_n,
    input  wire logic [WIDTH-1:0] port2_pins,
    input  wire logic [WIDTH-1:0] port2_wake_enable,
    input  wire logic [WIDTH-1:0] port2_active_high,
    input  pdc_pkg::pdc_exec_type exec_info,
    input  wire logic     watchdog_enable,
    input  wire logic     watchdog_overflow,
    input  pdc_pkg::pdc_ctrl_type ctrl,
    input  wire logic     watchdog_reset_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic go = exec_info.power_down_instruction && ctrl == 6'h3c;
    wire logic flt = exec_info.next_code_external && (exec_info.prev_write_external
        || exec_info.bus_multiplexed && !exec_info.tristate_wait_control);
    // Selected exit pin at its active level
    wire logic pin_on = |(port2_wake_enable & ~(port2_pins ^ port2_active_high));
    wire logic wk = wake_source_select ? pin_on : nmi_n;
    ign_nmi_a: assert property (go && !flt && !wake_source_select && nmi_n |=> ctrl == 6'h3c)
        else $error("instruction not ignored");
    ign_pin_a: assert property (go && !flt && wake_source_select && pin_on |=> ctrl == 6'h3c)
        else $error("instruction not ignored on pin");
    enter_pd_a: assert property (go && !wake_source_select && !nmi_n |=> ctrl == 6'h01)
        else $error("power-down not entered");
    pin_pd_a: assert property (go && wake_source_select && !pin_on |=> ctrl == 6'h01)
        else $error("power-down not entered on pins");
    quasi_in_a: assert property (go && flt && wk |=> ctrl == 6'h12)
        else $error("quasi-idle not entered");
    qi_stay_a: assert property (ctrl == 6'h12 |=> ctrl == ($past(nmi_n) ? 6'h12 : 6'h01))
        else $error("quasi-idle exit wrong");
    pd_stay_a: assert property (ctrl == 6'h01 && !wake_source_select
        |=> ctrl == ($past(nmi_n) ? 6'h3c : 6'h01)) else $error("power-down exit wrong");
    run_stay_a: assert property (ctrl == 6'h3c && !go |=> $stable(ctrl))
        else $error("run left without request");
    wdt_req_a: assert property (watchdog_enable && watchdog_overflow && !ctrl.power_down
        |=> watchdog_reset_req) else $error("watchdog reset missing");
    wdt_cause_a: assert property ($rose(watchdog_reset_req) |-> $past(watchdog_overflow))
        else $error("watchdog reset without overflow");
    cover property (go && flt);
    cover property (ctrl == 6'h12 && !nmi_n);
    cover property (watchdog_reset_req);
    cover property (go && flt && !wk);
endmodule // pdc_props
bind pdc_power_down_entry_control pdc_props #(.WIDTH(WIDTH)) u_props (.clk(clk), .nrst(nrst),
    .wake_source_select(wake_source_select), .nmi_n(nmi_n), .exec_info(exec_info),
    .port2_pins(port2_pins), .port2_wake_enable(port2_wake_enable),
    .port2_active_high(port2_active_high),
    .watchdog_enable(watchdog_enable), .watchdog_overflow(watchdog_overflow),
    .ctrl(ctrl), .watchdog_reset_req(watchdog_reset_req));

/* File: verif/pdc_power_down_entry_control_tb.sv */
`timescale 1ns/10ps
module pdc_power_down_entry_control_tb
    import pdc_pkg::*;
;
    logic         clk = 1'b0, nrst = 1'b0, sel = 1'b0, nmi_n = 1'b1, pd = 1'b0, ov = 1'b0;
    logic [1:0]   kind = 2'h0;
    logic [15:0]  pins = 16'h0000;
    pdc_exec_type ctx;
    pdc_ctrl_type ctrl;
    logic         req;
    logic         wde = 1'b1;
    int           num_errors = 0, n_tests = 0;
    initial forever #12.5 clk = ~clk;
    pdc_mem_model mem (.kind(kind), .pd(pd), .ctx(ctx));
    pdc_power_down_entry_control dut (.clk(clk), .nrst(nrst), .wake_source_select(sel),
        .nmi_n(nmi_n), .port2_pins(pins), .port2_wake_enable(16'h0008),
        .port2_active_high(16'h0008), .exec_info(ctx), .watchdog_enable(wde),
        .watchdog_overflow(ov), .ctrl(ctrl), .watchdog_reset_req(req));
    // --------
    // Helpers
    // --------
    task chk(logic [7:0] got, logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Pin b drives port 2 bit 3, the only enabled exit pin
    task go(logic p, s, n, b, logic [1:0] k, logic o, logic [7:0] ec, logic r);
        @(posedge clk);
        {pd, sel, nmi_n, pins[3], kind, ov} <= {p, s, n, b, k, o};
        @(posedge clk);
        {pd, ov} <= 2'h0;
        @(negedge clk);
        chk({2'h0, ctrl}, ec);
        chk({7'h00, req}, {7'h00, r});
    endtask
    task complete_run;
        $display("checks=%0d errors=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // --------
    // Scenarios
    // --------
    task t_nmi;
        go(1, 0, 1, 0, 0, 0, 8'h3c, 0);
        go(1, 0, 0, 1, 0, 1, 8'h01, 1);
        go(0, 0, 1, 0, 0, 0, 8'h3c, 0);
    endtask
    task t_port2;
        go(1, 1, 1, 1, 0, 0, 8'h3c, 0);
        go(1, 1, 1, 0, 0, 0, 8'h01, 0);
        go(0, 1, 0, 1, 0, 0, 8'h3c, 0);
    endtask
    task t_fault;
        for (int k = 1; k < 3; k++)
        begin
            go(1, 0, 1, 0, k[1:0], 0, 8'h12, 0);
            go(1, 0, 1, 0, 0, 1, 8'h12, 1);
            go(0, 0, 0, 0, 0, 0, 8'h01, 0);
            go(0, 0, 1, 0, 0, 0, 8'h3c, 0);
        end
        go(1, 0, 0, 0, 1, 0, 8'h01, 0);
        go(0, 0, 1, 0, 0, 0, 8'h3c, 0);
        go(1, 0, 1, 0, 3, 0, 8'h3c, 0);
        go(1, 1, 1, 1, 2, 0, 8'h12, 0);
        go(0, 1, 0, 0, 0, 0, 8'h01, 0);
        go(0, 1, 1, 1, 0, 0, 8'h3c, 0);
    endtask
    // Disabled watchdog must not ask for a reset
    task t_wdt_off;
        @(posedge clk);
        wde <= 1'b0;
        go(0, 0, 1, 0, 0, 1, 8'h3c, 0);
        @(posedge clk);
        wde <= 1'b1;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_nmi();
        t_port2();
        t_fault();
        t_wdt_off();
        complete_run();
    end
    initial
    begin
        #5000;
        num_errors++;
        complete_run();
    end
endmodule // pdc_power_down_entry_control_tb
